/* sbp_map.vh */
`ifndef SBP_MAP_VH
`define SBP_MAP_VH

// Data bus configurations
`define SBP_DW_X8        8
`define SBP_DW_X18       18
`define SBP_DW_X36       36
`define SBP_DW_MAX       36

// External address inputs per configuration
`define SBP_EXT_AW_X8    20
`define SBP_EXT_AW_X18   20
`define SBP_EXT_AW_X36   19
`define SBP_EXT_AW_MAX   20

// Internal array word address widths
`define SBP_MEM_AW_X8    21
`define SBP_MEM_AW_X18   20
`define SBP_MEM_AW_X36   19
`define SBP_MEM_AW_MAX   21

// Lane masks and lane widths
`define SBP_MASK_W       4
`define SBP_LANE_W_X8    4
`define SBP_LANE_W_WIDE  9

// Words per burst
`define SBP_BURST_LEN    2

`endif

/* sbp_mem.v */
`timescale 1ns/1ps
`default_nettype none

module sbp_mem #(
    parameter AW = 19,
    parameter DW = 36
) (
    input  wire          clk,
    input  wire          wr_en,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wr_data,
    input  wire [DW-1:0] wr_bit_en,
    output reg  [DW-1:0] rd_data
);

    reg [DW-1:0] store [0:(1<<AW)-1];

    // Merge with the stored word so masked lanes keep their old contents;
    // one process keeps the array single-driven
    always @(posedge clk) begin
        if (wr_en) begin
            store[addr] <= (store[addr] & ~wr_bit_en) | (wr_data & wr_bit_en);
        end
        rd_data <= store[addr];
    end

endmodule

`default_nettype wire

/* sbp_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "sbp_map.vh"

module sbp_port #(
    parameter DATA_W = `SBP_DW_X36
) (
    input  wire                       clk,
    input  wire                       rst,
    input  wire                       k_clk,
    input  wire                       k_clk_n,
    input  wire                       c_clk,
    input  wire                       c_clk_n,
    input  wire                       single_clk_mode,
    input  wire                       load_strobe_n,
    input  wire                       read_not_write,
    input  wire [`SBP_EXT_AW_MAX-1:0] addr,
    input  wire [`SBP_MASK_W-1:0]     byte_lane_mask_n,
    input  wire [DATA_W-1:0]          dq_in,
    output reg  [DATA_W-1:0]          dq_out,
    output reg                        dq_oe,
    output reg                        echo_timing_out,
    output reg                        echo_timing_out_n
);

    localparam MEM_AW = (DATA_W == `SBP_DW_X8)  ? `SBP_MEM_AW_X8 :
                        (DATA_W == `SBP_DW_X18) ? `SBP_MEM_AW_X18 : `SBP_MEM_AW_X36;

    // ************************************************************
    // Write capture states
    // ************************************************************
    localparam [2:0] WC_IDLE = 3'h1;
    localparam [2:0] WC_B0   = 3'h2;
    localparam [2:0] WC_B1   = 3'h4;

    // ************************************************************
    // Array port states
    // ************************************************************
    localparam [5:0] M_IDLE = 6'h01;
    localparam [5:0] M_WR0  = 6'h02;
    localparam [5:0] M_WR1  = 6'h04;
    localparam [5:0] M_RD0  = 6'h08;
    localparam [5:0] M_RD1  = 6'h10;
    localparam [5:0] M_RD2  = 6'h20;

    // ************************************************************
    // Read output states
    // ************************************************************
    localparam [3:0] RO_IDLE = 4'h1;
    localparam [3:0] RO_WAIT = 4'h2;
    localparam [3:0] RO_B1   = 4'h4;
    localparam [3:0] RO_END  = 4'h8;

    // ************************************************************
    // Functions
    // ************************************************************
    // Array word address of one beat of a burst
    function [`SBP_MEM_AW_MAX-1:0] word_addr;
        input [`SBP_EXT_AW_MAX-1:0] base;
        input                       beat;
        begin
            if (DATA_W == `SBP_DW_X8) begin
                word_addr = {base, beat};
            end else if (DATA_W == `SBP_DW_X18) begin
                word_addr = {1'b0, base[19:1], base[0] ^ beat};
            end else begin
                word_addr = {2'b00, base[18:1], base[0] ^ beat};
            end
        end
    endfunction

    // Bit write enables from the active-low lane masks of one beat
    function [`SBP_DW_MAX-1:0] lane_en;
        input [`SBP_MASK_W-1:0] mask_n;
        begin
            if (DATA_W == `SBP_DW_X8) begin
                lane_en = {28'h0000000, {`SBP_LANE_W_X8{~mask_n[1]}},
                           {`SBP_LANE_W_X8{~mask_n[0]}}};
            end else begin
                lane_en = {{`SBP_LANE_W_WIDE{~mask_n[3]}}, {`SBP_LANE_W_WIDE{~mask_n[2]}},
                           {`SBP_LANE_W_WIDE{~mask_n[1]}},
                           {`SBP_LANE_W_WIDE{~mask_n[0]}}};
            end
        end
    endfunction

    // ************************************************************
    // Clock edge detection
    // ************************************************************
    reg k_q;
    reg kn_q;
    reg oc_q;
    reg ocn_q;

    wire oc_lvl  = single_clk_mode ? k_clk : c_clk;
    wire ocn_lvl = single_clk_mode ? k_clk_n : c_clk_n;
    wire k_rise  = k_clk & ~k_q;
    wire kn_rise = k_clk_n & ~kn_q;
    wire oc_rise  = oc_lvl & ~oc_q;
    wire ocn_rise = ocn_lvl & ~ocn_q;

    always @(posedge clk) begin
        if (rst) begin
            // Track the pins during reset so release brings no false edge
            k_q   <= k_clk;
            kn_q  <= k_clk_n;
            oc_q  <= oc_lvl;
            ocn_q <= ocn_lvl;
            echo_timing_out   <= 1'b0;
            echo_timing_out_n <= 1'b0;
        end else begin
            k_q   <= k_clk;
            kn_q  <= k_clk_n;
            oc_q  <= oc_lvl;
            ocn_q <= ocn_lvl;
            // Free running, so no reference to any transfer state
            echo_timing_out   <= oc_lvl;
            echo_timing_out_n <= ocn_lvl;
        end
    end

    // ************************************************************
    // Load decode
    // ************************************************************
    reg  [2:0]                 wc_state;
    reg  [5:0]                 m_state;
    reg  [3:0]                 ro_state;
    reg                        wr_pend;
    reg                        rd_req;
    reg                        rd_ready;

    // A load arriving while its path is busy is dropped
    wire wr_free  = (wc_state == WC_IDLE) && !wr_pend;
    // The hand-over cycle counts as busy, or a new fetch would lose its burst
    wire rd_free  = !rd_req && (m_state[3] | m_state[4] | m_state[5]) == 1'b0
                    && (ro_state == RO_IDLE) && !rd_ready;
    wire load_now = k_rise && !load_strobe_n;
    wire load_wr  = load_now && !read_not_write && wr_free;
    wire load_rd  = load_now && read_not_write && rd_free;

    // ************************************************************
    // Write capture
    // ************************************************************
    reg [`SBP_EXT_AW_MAX-1:0] wr_base;
    reg [DATA_W-1:0]          wr_d0;
    reg [DATA_W-1:0]          wr_d1;
    reg [`SBP_MASK_W-1:0]     wr_m0;
    reg [`SBP_MASK_W-1:0]     wr_m1;
    reg [2:0]                 next_wc_state;

    always @* begin
        case (wc_state)
            WC_IDLE: next_wc_state = load_wr ? WC_B0 : WC_IDLE;
            WC_B0:   next_wc_state = k_rise ? WC_B1 : WC_B0;
            WC_B1:   next_wc_state = kn_rise ? WC_IDLE : WC_B1;
            default: next_wc_state = WC_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            wc_state <= WC_IDLE;
            wr_base  <= 20'h00000;
            wr_d0    <= {DATA_W{1'b0}};
            wr_d1    <= {DATA_W{1'b0}};
            wr_m0    <= 4'hF;
            wr_m1    <= 4'hF;
        end else begin
            wc_state <= next_wc_state;
            if (load_wr) begin
                wr_base <= addr;
            end
            if (wc_state == WC_B0 && k_rise) begin
                wr_d0 <= dq_in;
                wr_m0 <= byte_lane_mask_n;
            end
            if (wc_state == WC_B1 && kn_rise) begin
                wr_d1 <= dq_in;
                wr_m1 <= byte_lane_mask_n;
            end
        end
    end

    // ************************************************************
    // Array port sequencing
    // ************************************************************
    reg [`SBP_EXT_AW_MAX-1:0] rd_base;
    reg [DATA_W-1:0]          rbuf0;
    reg [DATA_W-1:0]          rbuf1;
    reg [5:0]                 next_m_state;
    wire [DATA_W-1:0]         mem_rd;

    wire                      wr_done = (wc_state == WC_B1) && kn_rise;

    always @* begin
        case (m_state)
            // Pending writes go first so a read after a write sees new data
            M_IDLE:  next_m_state = wr_pend ? M_WR0 : (rd_req ? M_RD0 : M_IDLE);
            M_WR0:   next_m_state = M_WR1;
            M_WR1:   next_m_state = M_IDLE;
            M_RD0:   next_m_state = M_RD1;
            M_RD1:   next_m_state = M_RD2;
            M_RD2:   next_m_state = M_IDLE;
            default: next_m_state = M_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            m_state  <= M_IDLE;
            wr_pend  <= 1'b0;
            rd_req   <= 1'b0;
            rd_base  <= 20'h00000;
            rbuf0    <= {DATA_W{1'b0}};
            rbuf1    <= {DATA_W{1'b0}};
            rd_ready <= 1'b0;
        end else begin
            m_state  <= next_m_state;
            rd_ready <= (m_state == M_RD2);
            if (wr_done) begin
                wr_pend <= 1'b1;
            end else if (m_state == M_WR1) begin
                wr_pend <= 1'b0;
            end
            if (load_rd) begin
                rd_req  <= 1'b1;
                rd_base <= addr;
            end else if (m_state == M_RD0) begin
                rd_req <= 1'b0;
            end
            if (m_state == M_RD1) begin
                rbuf0 <= mem_rd;
            end
            if (m_state == M_RD2) begin
                rbuf1 <= mem_rd;
            end
        end
    end

    wire                 beat1   = (m_state == M_WR1) || (m_state == M_RD1);
    wire                 is_wr   = (m_state == M_WR0) || (m_state == M_WR1);
    wire [`SBP_MEM_AW_MAX-1:0] full_addr = word_addr(is_wr ? wr_base : rd_base, beat1);
    wire [`SBP_DW_MAX-1:0]     full_ben  = lane_en(beat1 ? wr_m1 : wr_m0);
    wire [MEM_AW-1:0]    mem_addr = full_addr[MEM_AW-1:0];
    wire [DATA_W-1:0]    mem_ben  = full_ben[DATA_W-1:0];
    wire [DATA_W-1:0]    mem_wd   = beat1 ? wr_d1 : wr_d0;

    sbp_mem #(
        .AW (MEM_AW),
        .DW (DATA_W)
    ) u_mem (
        .clk       (clk),
        .wr_en     (is_wr),
        .addr      (mem_addr),
        .wr_data   (mem_wd),
        .wr_bit_en (mem_ben),
        .rd_data   (mem_rd)
    );

    // ************************************************************
    // Read output
    // ************************************************************
    reg [3:0] next_ro_state;

    always @* begin
        case (ro_state)
            RO_IDLE: next_ro_state = rd_ready ? RO_WAIT : RO_IDLE;
            RO_WAIT: next_ro_state = oc_rise ? RO_B1 : RO_WAIT;
            RO_B1:   next_ro_state = ocn_rise ? RO_END : RO_B1;
            RO_END:  next_ro_state = oc_rise ? RO_IDLE : RO_END;
            default: next_ro_state = RO_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            ro_state <= RO_IDLE;
            dq_out   <= {DATA_W{1'b0}};
            dq_oe    <= 1'b0;
        end else begin
            ro_state <= next_ro_state;
            if (ro_state == RO_WAIT && oc_rise) begin
                dq_out <= rbuf0;
                dq_oe  <= 1'b1;
            end else if (ro_state == RO_B1 && ocn_rise) begin
                dq_out <= rbuf1;
            end else if (ro_state == RO_END && oc_rise) begin
                dq_out <= {DATA_W{1'b0}};
                dq_oe  <= 1'b0;
            end else if (ro_state == RO_IDLE) begin
                dq_oe  <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* sbp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbp_map.vh"
// ****************************************************
// Controller model: free-running clock pairs and bursts
// ****************************************************
module sbp_ctrl_model #(
    parameter DATA_W = 36
) (
    input  wire logic                       clk,
    output var  logic                       k_clk,
    output var  logic                       k_clk_n,
    output var  logic                       c_clk,
    output var  logic                       c_clk_n,
    output var  logic                       load_strobe_n,
    output var  logic                       read_not_write,
    output var  logic [`SBP_EXT_AW_MAX-1:0] addr,
    output var  logic [`SBP_MASK_W-1:0]     byte_lane_mask_n,
    output var  logic [DATA_W-1:0]          dq_in
);
    int ph = 7;
    initial begin
        load_strobe_n = 1'b1;
        read_not_write = 1'b0;
        addr = '0;
        byte_lane_mask_n = '1;
        dq_in = '0;
    end
    // Phases last four cycles; the output pair lags k by a fixed two cycles
    always @(negedge clk) begin
        ph = (ph + 1) % 8;
        k_clk = ph < 4;
        k_clk_n = ph >= 4;
        c_clk = ((ph + 6) % 8) < 4;
        c_clk_n = ((ph + 6) % 8) >= 4;
    end
    task automatic to_ph(input int p);
        do begin
            @(negedge clk);
            #1;
        end while (ph != p);
    endtask
    task automatic load(input logic rnw, input logic [`SBP_EXT_AW_MAX-1:0] a);
        to_ph(0);
        load_strobe_n = 1'b0;
        read_not_write = rnw;
        addr = a;
        to_ph(4);
        load_strobe_n = 1'b1;
        addr = ~a;
    endtask
    task automatic burst(input logic [DATA_W-1:0] d0, d1, input logic [3:0] m0, m1);
        to_ph(0);
        dq_in = d0;
        byte_lane_mask_n = m0;
        to_ph(4);
        dq_in = d1;
        byte_lane_mask_n = m1;
        to_ph(0);
        // A released bus shows the inverse, never a stale match
        dq_in = ~d1;
        byte_lane_mask_n = ~m1;
    endtask
endmodule
`default_nettype wire

/* sbp_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sbp_port_checker #(
    parameter DATA_W = 36
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              k_clk,
    input wire logic              k_clk_n,
    input wire logic              c_clk,
    input wire logic              c_clk_n,
    input wire logic              single_clk_mode,
    input wire logic              load_strobe_n,
    input wire logic              read_not_write,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              echo_timing_out,
    input wire logic              echo_timing_out_n
);
    logic oc, ocn, k_q, rd_busy;
    assign oc = single_clk_mode ? k_clk : c_clk;
    assign ocn = single_clk_mode ? k_clk_n : c_clk_n;
    // Accepted read stays open until its burst has left the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            k_q <= k_clk;
            rd_busy <= 1'b0;
        end else begin
            k_q <= k_clk;
            if (k_clk && !k_q && !load_strobe_n && read_not_write) rd_busy <= 1'b1;
            else if ($fell(dq_oe)) rd_busy <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_echo_true: assert property (
        !$past(rst) |-> echo_timing_out == ($past(single_clk_mode) ? $past(k_clk) : $past(c_clk)))
        else $error("echo clock does not follow its source");
    a_echo_comp: assert property (
        !$past(rst) |-> echo_timing_out_n == ($past(single_clk_mode) ? $past(k_clk_n) : $past(c_clk_n)))
        else $error("complement echo clock does not follow its source");
    a_idle_quiet: assert property (!dq_oe |-> dq_out == '0)
        else $error("data driven while no read is selected");
    a_beat0_edge: assert property (
        $rose(dq_oe) |-> ($past(oc) && !$past(oc, 2)) || ($past(oc, 2) && !$past(oc, 3)))
        else $error("first read word not launched by output clock rise");
    a_beat1_edge: assert property (
        dq_oe && $past(dq_oe) && dq_out != $past(dq_out)
        |-> ($past(ocn) && !$past(ocn, 2)) || ($past(ocn, 2) && !$past(ocn, 3)))
        else $error("second read word not launched by complement clock rise");
    a_burst_end: assert property (
        $fell(dq_oe) |-> ($past(oc) && !$past(oc, 2)) || ($past(oc, 2) && !$past(oc, 3)))
        else $error("read burst not closed at next output clock rise");
    a_read_answer: assert property (
        k_clk && !k_q && !load_strobe_n && read_not_write && !rd_busy |-> ##[1:64] $rose(dq_oe))
        else $error("loaded read never answered");
    a_no_spurious: assert property ($rose(dq_oe) |-> rd_busy)
        else $error("data driven without a loaded read");
endmodule
bind sbp_port sbp_port_checker #(.DATA_W(DATA_W)) i_chk (
    .clk(clk), .rst(rst), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n),
    .single_clk_mode(single_clk_mode), .load_strobe_n(load_strobe_n),
    .read_not_write(read_not_write), .dq_out(dq_out), .dq_oe(dq_oe),
    .echo_timing_out(echo_timing_out), .echo_timing_out_n(echo_timing_out_n));
`default_nettype wire

/* two_word_burst_sram_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbp_map.vh"
module two_word_burst_sram_port_tb;
    localparam DW = `SBP_DW_X36;
    logic                       clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       single_clk_mode = 1'b0;
    wire                        k_clk, k_clk_n, c_clk, c_clk_n;
    wire                        load_strobe_n, read_not_write;
    wire  [`SBP_EXT_AW_MAX-1:0] addr;
    wire  [`SBP_MASK_W-1:0]     byte_lane_mask_n;
    wire  [DW-1:0]              dq_in, dq_out;
    wire                        dq_oe, echo_timing_out, echo_timing_out_n;
    int                         fails = 0;
    int                         checked = 0;
    int                         cycles = 0;
    logic [DW-1:0]              w0, w1;
    always #12.5 clk = ~clk;
    sbp_port #(.DATA_W(DW)) i_dut (
        .clk(clk), .rst(rst), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
        .c_clk_n(c_clk_n), .single_clk_mode(single_clk_mode), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .addr(addr), .byte_lane_mask_n(byte_lane_mask_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_timing_out(echo_timing_out),
        .echo_timing_out_n(echo_timing_out_n));
    sbp_ctrl_model #(.DATA_W(DW)) i_ctrl (
        .clk(clk), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n),
        .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
        .byte_lane_mask_n(byte_lane_mask_n), .dq_in(dq_in));
    task automatic final_report();
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [DW-1:0] exp, got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // First and last driven cycles of one read burst, sampled at settled falling edges
    task automatic get_read(input logic [`SBP_EXT_AW_MAX-1:0] a);
        int n;
        i_ctrl.load(1'b1, a);
        n = 0;
        w1 = 'x;
        while (dq_oe !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        w0 = dq_out;
        while (dq_oe === 1'b1 && n < 160) begin
            w1 = dq_out;
            @(negedge clk);
            n++;
        end
    endtask
    task automatic s_write_read();
        i_ctrl.load(1'b0, 20'h00010);
        i_ctrl.burst(36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
        get_read(20'h00010);
        check_val("even word 0", 36'h123456789, w0);
        check_val("even word 1", 36'hFEDCBA987, w1);
    endtask
    task automatic s_odd_start();
        i_ctrl.load(1'b0, 20'h00023);
        i_ctrl.burst(36'hA5A5A5A5A, 36'h5A5A5A5A5, 4'h0, 4'h0);
        get_read(20'h00022);
        check_val("wrapped word 0", 36'h5A5A5A5A5, w0);
        check_val("wrapped word 1", 36'hA5A5A5A5A, w1);
    endtask
    task automatic s_lane_mask();
        i_ctrl.load(1'b0, 20'h00040);
        i_ctrl.burst('1, '1, 4'h0, 4'h0);
        i_ctrl.load(1'b0, 20'h00040);
        i_ctrl.burst('0, '0, 4'hA, 4'h5);
        get_read(20'h00040);
        check_val("lanes beat 0", 36'hFF803FE00, w0);
        check_val("lanes beat 1", 36'h007FC01FF, w1);
    endtask
    task automatic s_idle_bus();
        int n, hits;
        hits = 0;
        for (n = 0; n < 48; n++) begin
            @(negedge clk);
            hits += (dq_oe !== 1'b0 || dq_out !== '0);
        end
        check_val("idle drive cycles", '0, DW'(hits));
    endtask
    task automatic s_single_clock();
        @(negedge clk);
        single_clk_mode = 1'b1;
        get_read(20'h00010);
        check_val("single word 0", 36'h123456789, w0);
        check_val("single word 1", 36'hFEDCBA987, w1);
        @(negedge clk);
        single_clk_mode = 1'b0;
    endtask
    // Ceiling sits well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        s_write_read();
        s_odd_start();
        s_lane_mask();
        s_idle_bus();
        s_single_clock();
        s_idle_bus();
        final_report();
    end
endmodule
`default_nettype wire
